// ### verilog/rcr_pkg.sv
// rcr_pkg: addresses, bit positions and reset values for the reset cause recorder
package rcr_pkg;
    // documented register addresses on the cpu data bus
    localparam logic [15:0] RCR_ADDR_CAUSE = 16'hFF54;
    localparam logic [15:0] RCR_ADDR_LVCTL = 16'hFF50;
    localparam logic [15:0] RCR_ADDR_LVLVL = 16'hFF51;
    // interrupt flag register addresses, placed in a free area of the map
    localparam logic [15:0] RCR_ADDR_IRQREQA = 16'hFFE0;
    localparam logic [15:0] RCR_ADDR_IRQREQB = 16'hFFE1;
    localparam logic [15:0] RCR_ADDR_IRQMSKA = 16'hFFE4;
    localparam logic [15:0] RCR_ADDR_IRQMSKB = 16'hFFE5;

    // cause register layout
    localparam int RCR_WDT_BIT = 4;
    localparam int RCR_LVR_BIT = 0;
    localparam logic [7:0] RCR_CAUSE_USED = 8'h11;

    // low-voltage control register layout
    localparam int RCR_LVCTL_ON_BIT = 7;
    localparam int RCR_LVCTL_MODE_BIT = 1;
    localparam int RCR_LVCTL_FLAG_BIT = 0;
    localparam int RCR_LVLVL_W = 4;

    // reset and idle values
    localparam logic [7:0] RCR_CAUSE_RST = 8'h00;
    localparam logic [7:0] RCR_LV_RST = 8'h00;
    localparam logic [RCR_LVLVL_W-1:0] RCR_LVLVL_RST = 4'h0;
    localparam logic [7:0] RCR_MASK_RST = 8'hFF;
    localparam logic [7:0] RCR_REQ_RST = 8'h00;
    localparam logic [7:0] RCR_RD_IDLE = 8'h00;
endpackage : rcr_pkg

// ### verilog/rcr_rst_sync.sv
// rcr_rst_sync: two-stage release synchroniser for the asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module rcr_rst_sync (
    input wire logic clk_sys,
    input wire logic arst_n,
    output logic rstSync_n
);
    logic meta_ff;
    logic hold_ff;

    // assert at once, release two edges later so no flop sees a runt release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            hold_ff <= meta_ff;
        end
    end

    assign rstSync_n = hold_ff;
endmodule : rcr_rst_sync
`default_nettype wire

// ### verilog/rcr_cause_flag.sv
// rcr_cause_flag: one sticky reset cause flag with clear and set priorities
`timescale 1ns/10ps
`default_nettype none
module rcr_cause_flag (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hardClr,
    input wire logic setReq,
    input wire logic readClr,
    output logic flagQ
);
    logic flag_ff;
    logic nxt_flag;

    // pin or power-on clear beats everything; a set beats a read clear
    always_comb begin
        nxt_flag = flag_ff;
        if (hardClr) begin
            nxt_flag = 1'b0;
        end else if (setReq) begin
            nxt_flag = 1'b1;
        end else if (readClr) begin
            nxt_flag = 1'b0;
        end
    end

    // the flag survives the internal reset it reports
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flagQ = flag_ff;
endmodule : rcr_cause_flag
`default_nettype wire

// ### verilog/rcr_top.sv
// rcr_top: internal reset combiner, reset cause register and reset-dependent registers
//
// Contract
// - A cause register records whether watchdog or low-voltage caused the last reset.
// - Software reads the cause register as one read-only 8-bit byte.
// - Pin reset, power-on clear and a completed software read clear it to zero.
// - Bit 4 flags a watchdog reset request; zero otherwise or after a clear.
// - Bit 0 flags a low-voltage reset request; zero otherwise or after a clear.
// - Watchdog or low-voltage reset sets its own flag instead of clearing the register.
// - Each of these two resets leaves the other source's flag unchanged.
// - Low-voltage control and level registers clear on pin, power-on, watchdog reset only.
// - Power-on clear asserts the internal reset when power first arrives.
// - Internal reset holds while supply is below threshold, releases at or above.
// - On reset interrupt masks become all ones and interrupt requests all zeros.
`timescale 1ns/10ps
`default_nettype none
module rcr_top (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic pinRstReq,
    input wire logic pocBelow,
    input wire logic wdtRstReq,
    input wire logic lvrRstReq,
    input wire logic lvBelow,
    input wire logic [7:0] irqSetA,
    input wire logic [7:0] irqSetB,
    input wire logic [15:0] cpuAddr,
    input wire logic cpuRd,
    input wire logic cpuWr,
    input wire logic [7:0] cpuWrData,
    output logic [7:0] cpuRdData,
    output logic cpuRdValid,
    output logic intRst_n,
    output logic lvEnable,
    output logic lvResetMode,
    output logic [3:0] lvLevel,
    output logic [7:0] irqMaskA,
    output logic [7:0] irqMaskB,
    output logic [7:0] irqReqA,
    output logic [7:0] irqReqB
);
    logic rstSync_n;
    logic anyReq;
    logic hardClr;
    logic lvRegClr;
    logic readCause;
    logic wdtFlag;
    logic lvrFlag;
    logic [7:0] causeByte;
    logic [7:0] nxt_rdData;
    logic intRst_ff;
    logic [7:0] rdData_ff;
    logic rdValid_ff;
    logic lvOn_ff;
    logic lvMode_ff;
    logic [rcr_pkg::RCR_LVLVL_W-1:0] lvLvl_ff;
    logic [7:0] mskA_ff;
    logic [7:0] mskB_ff;
    logic [7:0] reqA_ff;
    logic [7:0] reqB_ff;

    // address compare, shared by every read and write decode
    function automatic logic addrHit(input logic [15:0] a, input logic [15:0] reg_addr);
        return a == reg_addr;
    endfunction : addrHit

    // place the two flags in their byte; all other positions are constant zero
    function automatic logic [7:0] packCause(input logic wdt, input logic lvr);
        logic [7:0] b;
        b = rcr_pkg::RCR_CAUSE_RST;
        b[rcr_pkg::RCR_WDT_BIT] = wdt;
        b[rcr_pkg::RCR_LVR_BIT] = lvr;
        return b;
    endfunction : packCause

    rcr_rst_sync u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .rstSync_n(rstSync_n)
    );

    // reset source decode; pin and power-on clear are the only reset sources that erase causes
    assign anyReq = pinRstReq | pocBelow | wdtRstReq | lvrRstReq;
    assign hardClr = pinRstReq | pocBelow;
    assign lvRegClr = pinRstReq | pocBelow | wdtRstReq;
    assign readCause = cpuRd & addrHit(cpuAddr, rcr_pkg::RCR_ADDR_CAUSE);

    // internal reset is low from power-up and for every cycle a source asks for it
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            intRst_ff <= 1'b0;
        end else begin
            intRst_ff <= ~anyReq;
        end
    end

    // cause flags sit outside the internal reset so they can report it
    rcr_cause_flag u_wdt_flag (
        .clk_sys(clk_sys),
        .rst_n(rstSync_n),
        .hardClr(hardClr),
        .setReq(wdtRstReq),
        .readClr(readCause),
        .flagQ(wdtFlag)
    );

    rcr_cause_flag u_lvr_flag (
        .clk_sys(clk_sys),
        .rst_n(rstSync_n),
        .hardClr(hardClr),
        .setReq(lvrRstReq),
        .readClr(readCause),
        .flagQ(lvrFlag)
    );

    assign causeByte = packCause(wdtFlag, lvrFlag);

    // read mux; unmapped addresses return zero
    always_comb begin
        nxt_rdData = rcr_pkg::RCR_RD_IDLE;
        if (addrHit(cpuAddr, rcr_pkg::RCR_ADDR_CAUSE)) begin
            nxt_rdData = causeByte;
        end else if (addrHit(cpuAddr, rcr_pkg::RCR_ADDR_LVCTL)) begin
            nxt_rdData[rcr_pkg::RCR_LVCTL_ON_BIT] = lvOn_ff;
            nxt_rdData[rcr_pkg::RCR_LVCTL_MODE_BIT] = lvMode_ff;
            nxt_rdData[rcr_pkg::RCR_LVCTL_FLAG_BIT] = lvBelow & lvOn_ff;
        end else if (addrHit(cpuAddr, rcr_pkg::RCR_ADDR_LVLVL)) begin
            nxt_rdData[rcr_pkg::RCR_LVLVL_W-1:0] = lvLvl_ff;
        end else if (addrHit(cpuAddr, rcr_pkg::RCR_ADDR_IRQREQA)) begin
            nxt_rdData = reqA_ff;
        end else if (addrHit(cpuAddr, rcr_pkg::RCR_ADDR_IRQREQB)) begin
            nxt_rdData = reqB_ff;
        end else if (addrHit(cpuAddr, rcr_pkg::RCR_ADDR_IRQMSKA)) begin
            nxt_rdData = mskA_ff;
        end else if (addrHit(cpuAddr, rcr_pkg::RCR_ADDR_IRQMSKB)) begin
            nxt_rdData = mskB_ff;
        end
    end

    // read data is captured on the same edge that clears the cause flags,
    // so the byte returned is the value from before the clear
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rdData_ff <= rcr_pkg::RCR_RD_IDLE;
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= cpuRd;
            if (cpuRd) begin
                rdData_ff <= nxt_rdData;
            end
        end
    end

    // low-voltage settings survive a reset the detector itself raised
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            lvOn_ff <= rcr_pkg::RCR_LV_RST[rcr_pkg::RCR_LVCTL_ON_BIT];
            lvMode_ff <= rcr_pkg::RCR_LV_RST[rcr_pkg::RCR_LVCTL_MODE_BIT];
        end else if (lvRegClr) begin
            lvOn_ff <= rcr_pkg::RCR_LV_RST[rcr_pkg::RCR_LVCTL_ON_BIT];
            lvMode_ff <= rcr_pkg::RCR_LV_RST[rcr_pkg::RCR_LVCTL_MODE_BIT];
        end else if (cpuWr && addrHit(cpuAddr, rcr_pkg::RCR_ADDR_LVCTL)) begin
            lvOn_ff <= cpuWrData[rcr_pkg::RCR_LVCTL_ON_BIT];
            lvMode_ff <= cpuWrData[rcr_pkg::RCR_LVCTL_MODE_BIT];
        end
    end

    // level select keeps only the four documented bits
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            lvLvl_ff <= rcr_pkg::RCR_LVLVL_RST;
        end else if (lvRegClr) begin
            lvLvl_ff <= rcr_pkg::RCR_LVLVL_RST;
        end else if (cpuWr && addrHit(cpuAddr, rcr_pkg::RCR_ADDR_LVLVL)) begin
            lvLvl_ff <= cpuWrData[rcr_pkg::RCR_LVLVL_W-1:0];
        end
    end

    // interrupt masks: every reset source reinitialises them
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            mskA_ff <= rcr_pkg::RCR_MASK_RST;
            mskB_ff <= rcr_pkg::RCR_MASK_RST;
        end else if (anyReq) begin
            mskA_ff <= rcr_pkg::RCR_MASK_RST;
            mskB_ff <= rcr_pkg::RCR_MASK_RST;
        end else if (cpuWr) begin
            if (addrHit(cpuAddr, rcr_pkg::RCR_ADDR_IRQMSKA)) begin
                mskA_ff <= cpuWrData;
            end
            if (addrHit(cpuAddr, rcr_pkg::RCR_ADDR_IRQMSKB)) begin
                mskB_ff <= cpuWrData;
            end
        end
    end

    // interrupt requests: hardware sets win over a software write of zero
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            reqA_ff <= rcr_pkg::RCR_REQ_RST;
            reqB_ff <= rcr_pkg::RCR_REQ_RST;
        end else if (anyReq) begin
            reqA_ff <= rcr_pkg::RCR_REQ_RST;
            reqB_ff <= rcr_pkg::RCR_REQ_RST;
        end else begin
            if (cpuWr && addrHit(cpuAddr, rcr_pkg::RCR_ADDR_IRQREQA)) begin
                reqA_ff <= cpuWrData | irqSetA;
            end else begin
                reqA_ff <= reqA_ff | irqSetA;
            end
            if (cpuWr && addrHit(cpuAddr, rcr_pkg::RCR_ADDR_IRQREQB)) begin
                reqB_ff <= cpuWrData | irqSetB;
            end else begin
                reqB_ff <= reqB_ff | irqSetB;
            end
        end
    end

    // outputs
    assign cpuRdData = rdData_ff;
    assign cpuRdValid = rdValid_ff;
    assign intRst_n = intRst_ff;
    assign lvEnable = lvOn_ff;
    assign lvResetMode = lvMode_ff;
    assign lvLevel = lvLvl_ff;
    assign irqMaskA = mskA_ff;
    assign irqMaskB = mskB_ff;
    assign irqReqA = reqA_ff;
    assign irqReqB = reqB_ff;

    // checks; bit-read misuse by software cannot be seen here, only byte reads
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstSync_n);

    // reset request and release; the repeat in a_poc_hold is kept short on purpose,
    // a longer hold is still caught cycle by cycle by a_rst_on_request
    a_rst_on_request: assert property (anyReq |=> !intRst_n)
        else $error("internal reset not asserted after a request");
    a_rst_release: assert property (!anyReq |=> intRst_n)
        else $error("internal reset not released with no request");
    a_poc_hold: assert property (pocBelow [*3] |=> !intRst_n [*1])
        else $error("internal reset dropped while supply below threshold");
    a_poc_rise: assert property ($rose(pocBelow) |=> !intRst_n)
        else $error("supply drop did not assert internal reset");

    // cause flags: set, hold across the other source, clear
    a_wdt_sets: assert property (wdtRstReq && !hardClr |=> causeByte[rcr_pkg::RCR_WDT_BIT])
        else $error("watchdog flag not set");
    a_lvr_sets: assert property (lvrRstReq && !hardClr |=> causeByte[rcr_pkg::RCR_LVR_BIT])
        else $error("low-voltage flag not set");
    a_wdt_keeps_lvr: assert property (wdtRstReq && !lvrRstReq && !hardClr && !readCause
        |=> causeByte[rcr_pkg::RCR_LVR_BIT] == $past(causeByte[rcr_pkg::RCR_LVR_BIT]))
        else $error("watchdog reset disturbed the low-voltage flag");
    a_lvr_keeps_wdt: assert property (lvrRstReq && !wdtRstReq && !hardClr && !readCause
        |=> $stable(causeByte[rcr_pkg::RCR_WDT_BIT]))
        else $error("low-voltage reset disturbed the watchdog flag");
    a_hard_clear: assert property (hardClr |=> causeByte == rcr_pkg::RCR_CAUSE_RST)
        else $error("pin or power-on reset did not clear causes");
    a_read_clear: assert property (readCause && !wdtRstReq && !lvrRstReq
        |=> cpuRdValid && causeByte == rcr_pkg::RCR_CAUSE_RST)
        else $error("cause read did not clear flags");
    a_set_wins: assert property (readCause && wdtRstReq && !hardClr
        |=> causeByte[rcr_pkg::RCR_WDT_BIT])
        else $error("read clear beat a watchdog set");
    a_cause_read_only: assert property (cpuWr && cpuAddr == rcr_pkg::RCR_ADDR_CAUSE
        && !cpuRd && !anyReq |=> $stable(causeByte))
        else $error("write changed the cause register");

    // read path
    a_read_data: assert property (readCause |=> cpuRdData == $past(causeByte))
        else $error("cause read returned wrong byte");
    a_unused_zero: assert property (readCause |=> (cpuRdData & ~rcr_pkg::RCR_CAUSE_USED) == 8'h00)
        else $error("unused cause bit read as one");
    a_read_valid: assert property (cpuRdValid |-> $past(cpuRd))
        else $error("read valid without a read");

    // low-voltage settings and interrupt registers
    a_lv_clear: assert property (lvRegClr |=> !lvEnable && !lvResetMode && lvLevel == rcr_pkg::RCR_LVLVL_RST)
        else $error("low-voltage settings not cleared");
    a_lv_held: assert property (lvrRstReq && !lvRegClr && !cpuWr
        |=> $stable({lvEnable, lvResetMode, lvLevel}))
        else $error("low-voltage settings lost on own reset");
    a_lv_write: assert property (cpuWr && cpuAddr == rcr_pkg::RCR_ADDR_LVCTL && !lvRegClr
        |=> lvEnable == $past(cpuWrData[rcr_pkg::RCR_LVCTL_ON_BIT]))
        else $error("low-voltage control write lost");
    a_irq_init: assert property (anyReq |=>
        irqMaskA == rcr_pkg::RCR_MASK_RST && irqMaskB == rcr_pkg::RCR_MASK_RST
        && irqReqA == rcr_pkg::RCR_REQ_RST && irqReqB == rcr_pkg::RCR_REQ_RST)
        else $error("interrupt registers not reinitialised");
    a_irq_set_kept: assert property (!anyReq && irqSetA != 8'h00 |=> (irqReqA & $past(irqSetA)) == $past(irqSetA))
        else $error("interrupt request set bit lost");

    // scenarios worth seeing
    c_wdt_then_read: cover property (wdtRstReq ##[1:8] readCause);
    c_lvr_reset: cover property (lvrRstReq && !wdtRstReq ##1 !anyReq);
    c_poc_cycle: cover property (pocBelow [*2] ##1 !pocBelow);
    c_set_on_read: cover property (readCause && lvrRstReq);
    c_pin_clear: cover property (pinRstReq ##1 causeByte == rcr_pkg::RCR_CAUSE_RST);
endmodule : rcr_top
`default_nettype wire

// ### sim/rcr_cpu_model.sv
// rcr_cpu_model: cpu bus master and reset request sources facing the recorder
`timescale 1ns/10ps
`default_nettype none
module rcr_cpu_model (
    input wire logic clk_sys,
    input wire logic [7:0] cpuRdData,
    input wire logic cpuRdValid,
    output logic [15:0] cpuAddr,
    output logic cpuRd,
    output logic cpuWr,
    output logic [7:0] cpuWrData,
    output logic [3:0] rstReq
);
    // idle bus with strobes low and no request pending
    initial begin
        cpuAddr = 16'h0000;
        cpuRd = 1'b0;
        cpuWr = 1'b0;
        cpuWrData = 8'h00;
        rstReq = 4'h0;
    end
    // byte write; data is inverted once released so a stale value is never trusted
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cpuAddr <= a;
        cpuWrData <= d;
        cpuWr <= 1'b1;
        @(posedge clk_sys);
        cpuWr <= 1'b0;
        cpuWrData <= ~d;
    endtask : wr
    // whole-byte read only: a bit read would clear the cause flags unseen
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_sys);
        cpuAddr <= a;
        cpuRd <= 1'b1;
        @(posedge clk_sys);
        cpuRd <= 1'b0;
        #1;
        d = cpuRdData;
        v = cpuRdValid;
    endtask : rd
    // request lines {pin, poc, wdt, lvr} held for n sampled edges
    task automatic req(input logic [3:0] r, input int n);
        @(posedge clk_sys);
        rstReq <= r;
        repeat (n) @(posedge clk_sys);
        rstReq <= 4'h0;
    endtask : req
endmodule : rcr_cpu_model
`default_nettype wire

// ### sim/reset_cause_recorder_bench.sv
// reset_cause_recorder_bench: directed scenarios for the reset cause recorder
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errorCnt++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module reset_cause_recorder_bench;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic lvBelow = 1'b0;
    logic [7:0] irqSetA = 8'h00;
    logic [7:0] irqSetB = 8'h00;
    logic [15:0] cpuAddr;
    logic cpuRd, cpuWr, cpuRdValid, intRst_n, lvEnable, lvResetMode, vld;
    logic [7:0] cpuWrData, cpuRdData, irqMaskA, irqMaskB, irqReqA, irqReqB, rdv;
    logic [3:0] lvLevel, rstReq;
    int errorCnt = 0;
    int checked = 0;
    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;
    rcr_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .pinRstReq(rstReq[3]), .pocBelow(rstReq[2]),
        .wdtRstReq(rstReq[1]), .lvrRstReq(rstReq[0]), .lvBelow(lvBelow), .irqSetA(irqSetA),
        .irqSetB(irqSetB), .cpuAddr(cpuAddr), .cpuRd(cpuRd), .cpuWr(cpuWr), .cpuWrData(cpuWrData),
        .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid), .intRst_n(intRst_n), .lvEnable(lvEnable),
        .lvResetMode(lvResetMode), .lvLevel(lvLevel), .irqMaskA(irqMaskA), .irqMaskB(irqMaskB),
        .irqReqA(irqReqA), .irqReqB(irqReqB));
    rcr_cpu_model u_cpu (.clk_sys(clk_sys), .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid),
        .cpuAddr(cpuAddr), .cpuRd(cpuRd), .cpuWr(cpuWr), .cpuWrData(cpuWrData), .rstReq(rstReq));
    // read a byte and judge both the data and its valid strobe
    task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
        u_cpu.rd(a, rdv, vld);
        `CHK("rdValid", 1'b1, vld)
        `CHK("rdData", e, rdv)
    endtask : rdChk
    // power-up: reset holds everything, then the cause register reads empty
    task automatic tPowerUp();
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("intRst_n", 1'b0, intRst_n)
        `CHK("irqMaskB", 8'hFF, irqMaskB)
        `CHK("irqReqB", 8'h00, irqReqB)
        @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK("intRst_n", 1'b1, intRst_n)
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h00);
        rdChk(16'hFF00, 8'h00);
    endtask : tPowerUp
    // watchdog reset: sets bit 4, clears detector setup and interrupt state
    task automatic tWatchdog();
        u_cpu.wr(rcr_pkg::RCR_ADDR_LVCTL, 8'h82);
        u_cpu.wr(rcr_pkg::RCR_ADDR_LVLVL, 8'h05);
        u_cpu.wr(rcr_pkg::RCR_ADDR_IRQMSKA, 8'h0F);
        @(posedge clk_sys);
        irqSetA <= 8'h05;
        irqSetB <= 8'h0A;
        @(posedge clk_sys);
        irqSetA <= 8'h00;
        irqSetB <= 8'h00;
        #1;
        `CHK("setup", 11'h6AF, {lvEnable, lvResetMode, lvLevel, irqMaskA[4:0]})
        `CHK("irqReqA", 8'h05, irqReqA)
        `CHK("irqReqB", 8'h0A, irqReqB)
        u_cpu.req(4'h2, 1);
        #1;
        `CHK("intRst_n", 1'b0, intRst_n)
        `CHK("lvRegs", 6'h00, {lvEnable, lvResetMode, lvLevel})
        `CHK("irqMaskA", 8'hFF, irqMaskA)
        `CHK("irqReqA", 8'h00, irqReqA)
        @(posedge clk_sys);
        #1;
        `CHK("intRst_n", 1'b1, intRst_n)
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h10);
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h00);
    endtask : tWatchdog
    // low-voltage reset keeps detector setup and the watchdog flag;
    // the watchdog reset comes first, since it would wipe the setup itself
    task automatic tLowVolt();
        u_cpu.req(4'h2, 1);
        u_cpu.wr(rcr_pkg::RCR_ADDR_LVCTL, 8'h82);
        u_cpu.wr(rcr_pkg::RCR_ADDR_LVLVL, 8'h09);
        u_cpu.req(4'h1, 1);
        #1;
        `CHK("lvRegs", 6'h39, {lvEnable, lvResetMode, lvLevel})
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h11);
        u_cpu.req(4'h1, 1);
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h01);
        @(posedge clk_sys);
        lvBelow <= 1'b1;
        rdChk(rcr_pkg::RCR_ADDR_LVCTL, 8'h83);
        @(posedge clk_sys);
        lvBelow <= 1'b0;
    endtask : tLowVolt
    // pin and power-on clear wipe both flags; power-on clear holds reset while low
    task automatic tHardClear();
        u_cpu.req(4'h3, 1);
        u_cpu.req(4'h8, 1);
        #1;
        `CHK("lvLevel", 4'h0, lvLevel)
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h00);
        u_cpu.req(4'h3, 1);
        u_cpu.req(4'h4, 5);
        #1;
        `CHK("intRst_n", 1'b0, intRst_n)
        @(posedge clk_sys);
        #1;
        `CHK("intRst_n", 1'b1, intRst_n)
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h00);
    endtask : tHardClear
    // a watchdog set landing on the clearing read must survive it
    task automatic tRace();
        fork
            u_cpu.rd(rcr_pkg::RCR_ADDR_CAUSE, rdv, vld);
            u_cpu.req(4'h2, 1);
        join
        `CHK("preClear", 8'h00, rdv)
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h10);
    endtask : tRace
    // cause register ignores writes and keeps unused bits at zero
    task automatic tReadOnly();
        u_cpu.wr(rcr_pkg::RCR_ADDR_CAUSE, 8'hFF);
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h00);
        u_cpu.req(4'h3, 2);
        rdChk(rcr_pkg::RCR_ADDR_CAUSE, 8'h11);
    endtask : tReadOnly
    // counts, verdict and end of run
    task automatic completeRun();
        $display("checked %0d errorCnt %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : completeRun
    // main sequence
    initial begin
        tPowerUp();
        tWatchdog();
        tLowVolt();
        tHardClear();
        tRace();
        tReadOnly();
        completeRun();
    end
    // hang guard, well beyond the roughly 75 cycles the scenarios need
    initial begin
        repeat (3000) @(posedge clk_sys);
        errorCnt++;
        completeRun();
    end
endmodule : reset_cause_recorder_bench
`default_nettype wire
